/* File: design/sarr_pkg.sv */
// Constants shared by the converter readout control
package sarr_pkg;
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned CONV_MIN_NS = 1350;
   localparam int unsigned CONV_MAX_NS = 1500;
   localparam int unsigned CONV_CYC =
      (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 5;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned TOP_BIT = 15;
   localparam int unsigned LAST_BIT = 15;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [15:0] CONFIG_RST = 16'h0000;
   typedef enum logic {
      SARR_IDLE,
      SARR_CONV
   } sarr_state_t;
endpackage

/* File: design/sarr_top.sv */
// Conversion start and serial readout control with its sample FIFO
`timescale 1ns/1ps

module sarr_fifo #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0] count, next_count;
   logic push, pop;

   always_comb begin
      in_ready = (count != (AW+1)'(DEPTH));
      out_valid = (count != '0);
      out_data = mem[rd_ptr];
      push = in_valid && in_ready;
      pop = out_valid && out_ready;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
      next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

module sarr_top (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Sampled words from the front end
   input wire logic sample_valid,
   output logic sample_ready,
   input wire logic [15:0] sample_data,
   // Serial link pins
   input wire logic convert_start_strobe,
   input wire logic sclk,
   input wire logic din,
   output logic dout,
   output logic dout_oe,
   // Mode strap and status
   input wire logic daisy_mode,
   output logic conv_busy,
   output logic [15:0] config_word
);
   logic cs_s1, cs_s2, cs_q, ck_s1, ck_s2, ck_q, di_s1, di_s2, md_s1, md_s2;
   logic cs_rise, cs_fall, sclk_rise, sclk_fall;
   logic fifo_valid, fifo_ready, fifo_in_ready;
   logic [15:0] fifo_data;
   sarr_pkg::sarr_state_t state, next_state;
   logic [sarr_pkg::CNT_W-1:0] conv_cnt, next_conv_cnt;
   logic [15:0] result, next_result, held, next_held;
   logic result_ready, next_result_ready;
   logic [15:0] shift, next_shift, next_config;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic next_dout, next_dout_oe, next_sample_ready;

   sarr_fifo #(.WIDTH(sarr_pkg::WORD_W), .DEPTH(sarr_pkg::FIFO_DEPTH)) u_fifo (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .in_valid(sample_valid && sample_ready),
      .in_ready(fifo_in_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );

   // Pin synchronisers and edge finders
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         {cs_s1, cs_s2, cs_q} <= 3'h0;
         {ck_s1, ck_s2, ck_q} <= 3'h0;
         {di_s1, di_s2, md_s1, md_s2} <= 4'h0;
      end else begin
         cs_s1 <= convert_start_strobe;
         cs_s2 <= cs_s1;
         cs_q <= cs_s2;
         ck_s1 <= sclk;
         ck_s2 <= ck_s1;
         ck_q <= ck_s2;
         di_s1 <= din;
         di_s2 <= di_s1;
         md_s1 <= daisy_mode;
         md_s2 <= md_s1;
      end
   end

   always_comb begin
      cs_rise = cs_s2 && !cs_q;
      cs_fall = !cs_s2 && cs_q;
      sclk_rise = ck_s2 && !ck_q;
      sclk_fall = !ck_s2 && ck_q;
   end

   // Conversion timer
   always_comb begin
      next_state = state;
      next_conv_cnt = conv_cnt;
      next_result = result;
      next_held = held;
      next_result_ready = result_ready;
      fifo_ready = 1'b0;
      case (state)
         sarr_pkg::SARR_IDLE, sarr_pkg::SARR_CONV: begin
            if (cs_rise) begin
               fifo_ready = 1'b1;
               if (fifo_valid) begin
                  next_held = fifo_data;
               end
               next_state = sarr_pkg::SARR_CONV;
               next_conv_cnt = sarr_pkg::CNT_W'(sarr_pkg::CONV_CYC - 1);
               next_result_ready = 1'b0;
            end else if (state == sarr_pkg::SARR_CONV) begin
               if (conv_cnt == '0) begin
                  next_state = sarr_pkg::SARR_IDLE;
                  next_result = held;
                  next_result_ready = 1'b1;
               end else begin
                  next_conv_cnt = conv_cnt - 1'b1;
               end
            end
         end
         default: next_state = sarr_pkg::SARR_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= sarr_pkg::SARR_IDLE;
         conv_cnt <= '0;
         result <= sarr_pkg::RESULT_RST;
         held <= sarr_pkg::RESULT_RST;
         result_ready <= 1'b0;
      end else begin
         state <= next_state;
         conv_cnt <= next_conv_cnt;
         result <= next_result;
         held <= next_held;
         result_ready <= next_result_ready;
      end
   end

   // Serial shifter
   always_comb begin
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_dout = dout;
      next_dout_oe = dout_oe;
      next_config = config_word;
      // Ready drops after each take, so a full FIFO never loses a word
      next_sample_ready = fifo_in_ready && !(sample_valid && sample_ready);
      if (sclk_rise) begin
         if (md_s2) begin
            next_shift = {shift[15:1], di_s2};
         end else begin
            next_config = {config_word[14:0], di_s2};
         end
      end
      if (cs_s2) begin
         next_dout_oe = 1'b0;
      end else if (cs_fall && ck_s2 && result_ready) begin
         next_dout = result[sarr_pkg::TOP_BIT];
         next_shift = {result[14:0], 1'b0};
         next_bit_cnt = '0;
         next_dout_oe = 1'b1;
      end else if (dout_oe && sclk_fall) begin
         if (bit_cnt == 4'(sarr_pkg::LAST_BIT) && !md_s2) begin
            next_dout_oe = 1'b0;
         end else begin
            next_dout = shift[15];
            next_shift = {shift[14:0], 1'b0};
            next_bit_cnt = bit_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         shift <= '0;
         bit_cnt <= '0;
         dout <= 1'b0;
         dout_oe <= 1'b0;
         config_word <= sarr_pkg::CONFIG_RST;
         sample_ready <= 1'b0;
         conv_busy <= 1'b0;
      end else begin
         shift <= next_shift;
         bit_cnt <= next_bit_cnt;
         dout <= next_dout;
         dout_oe <= next_dout_oe;
         config_word <= next_config;
         sample_ready <= next_sample_ready;
         conv_busy <= (next_state == sarr_pkg::SARR_CONV);
      end
   end

   conv_start_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      cs_rise |=> state == sarr_pkg::SARR_CONV &&
         conv_cnt == sarr_pkg::CNT_W'(sarr_pkg::CONV_CYC - 1))
      else $error("conversion did not restart on strobe rise");
   select_gate_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      cs_fall && !ck_s2 |=> !dout_oe)
      else $error("serial port enabled with serial clock low");
   dout_edge_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      dout_oe && $past(dout_oe) && $changed(dout) |-> $past(sclk_fall))
      else $error("serial output moved off a falling edge");
   cfg_capture_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      sclk_rise && !md_s2 |=> config_word == {$past(config_word[14:0]),
         $past(di_s2)})
      else $error("configuration bit not captured");
   conv_done_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $fell(conv_busy) |-> result_ready && $past(conv_cnt) == '0 &&
         sarr_pkg::CONV_CYC <= sarr_pkg::CONV_MAX_CYC)
      else $error("result not ready at end of conversion");
   msb_first_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      $rose(dout_oe) |-> dout == $past(result[15]) && bit_cnt == '0)
      else $error("first bit out is not the top result bit");
   release_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      (cs_s2 || (dout_oe && sclk_fall && !md_s2 && bit_cnt == 4'hF))
      |=> !dout_oe)
      else $error("serial output not released");
   daisy_shift_a: assert property (@(posedge clk_sys) disable iff (!nrst)
      md_s2 && sclk_rise && !sclk_fall && !cs_fall |=> shift[0] ==
         $past(di_s2))
      else $error("daisy chain input not shifted in");
endmodule

/* File: dv/sarr_host.sv */
// Host model that starts conversions and reads words over the serial link
`timescale 1ns/1ps
module sarr_host (
   // Serial link pins
   output logic convert_start_strobe,
   output logic sclk,
   output logic din,
   input wire logic dout,
   input wire logic dout_oe,
   // Received word and output enable seen
   output logic [15:0] rx_word,
   output logic rx_valid,
   output logic oe_rise,
   output logic oe_sel,
   output logic oe_end
);
   initial begin
      {convert_start_strobe, sclk, din, rx_valid} = 4'h0;
      {oe_rise, oe_sel, oe_end} = 3'h0;
      rx_word = 16'h0000;
   end
   // A low sel makes the strobe fall with the clock low
   task automatic frame(input logic sel, input logic [15:0] cfg);
      convert_start_strobe = 1'b1;
      #300 oe_rise = dout_oe;
      #1300 sclk = sel;
      #200 convert_start_strobe = 1'b0;
      #400 oe_sel = dout_oe;
      for (int i = 0; i < 16; i++) begin
         rx_word[15-i] = dout_oe ? dout : !dout;
         sclk = 1'b0;
         din = cfg[15-i];
         #200 sclk = 1'b1;
         #200;
      end
      oe_end = dout_oe;
      rx_valid = sel;
      #50 rx_valid = 1'b0;
   endtask
endmodule

/* File: dv/test_sarr_top.sv */
// Self-checking bench for the converter readout control
`timescale 1ns/1ps
module test_sarr_top;
   logic clk_sys, nrst, sample_valid, sample_ready, daisy_mode, conv_busy;
   logic [15:0] sample_data, config_word, rx_word, last, w;
   logic strobe, sclk, din, dout, dout_oe, rx_valid, oe_rise, oe_sel, oe_end;
   logic [15:0] exp[$];
   int n_errors = 0;
   int n_checks = 0;
   int busy_n = 0;
   integer seed = 30;
   sarr_top u_sarr_top (.clk_sys(clk_sys), .nrst(nrst),
      .sample_valid(sample_valid), .sample_ready(sample_ready),
      .sample_data(sample_data), .convert_start_strobe(strobe),
      .sclk(sclk), .din(din), .dout(dout), .dout_oe(dout_oe),
      .daisy_mode(daisy_mode), .conv_busy(conv_busy),
      .config_word(config_word));
   sarr_host u_sarr_host (.convert_start_strobe(strobe), .sclk(sclk),
      .din(din), .dout(dout), .dout_oe(dout_oe), .rx_word(rx_word),
      .rx_valid(rx_valid), .oe_rise(oe_rise), .oe_sel(oe_sel),
      .oe_end(oe_end));
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, want, seen);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic push(input logic [15:0] v);
      @(negedge clk_sys);
      sample_valid = 1'b1;
      sample_data = v;
      while (sample_ready !== 1'b1) @(negedge clk_sys);
      exp.push_back(v);
      last = v;
      @(negedge clk_sys);
      sample_valid = 1'b0;
   endtask
   // Read one word and check the enable at each stage
   task automatic rd(input logic dm, input logic [2:0] oe);
      w = 16'($random(seed));
      @(negedge clk_sys) daisy_mode = dm;
      u_sarr_host.frame(1'b1, w);
      check("oe_rise", oe_rise, oe[2]);
      check("oe_sel", oe_sel, oe[1]);
      check("oe_end", oe_end, oe[0]);
      if (!dm) check("config", config_word, w);
   endtask
   always @(posedge rx_valid) check("word", rx_word, exp.pop_front());
   always @(posedge clk_sys) begin
      if (conv_busy === 1'b1) busy_n <= busy_n + 1;
      else if (busy_n != 0) begin
         check("busy_len", busy_n, sarr_pkg::CONV_CYC);
         busy_n <= 0;
      end
   end
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   initial begin
      #400000 n_errors++;
      test_done();
   end
   initial begin
      {nrst, sample_valid, daisy_mode} = 3'h0;
      sample_data = 16'h0000;
      repeat (4) @(negedge clk_sys);
      nrst = 1'b1;
      repeat (16) push(16'($random(seed)));
      repeat (2) @(negedge clk_sys);
      check("full", sample_ready, 1'b0);
      repeat (16) rd(1'b0, 3'h2);
      exp.push_back(last);
      rd(1'b0, 3'h2);
      u_sarr_host.frame(1'b0, 16'hFFFF);
      check("refused", oe_sel, 1'b0);
      exp.push_back(last);
      rd(1'b1, 3'h3);
      exp.push_back(last);
      rd(1'b0, 3'h2);
      #1000 check("drained", exp.size(), 0);
      test_done();
   end
endmodule
